// *** sync_cmd_pkg.sv ***
package sync_cmd_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] addr_oneshot      = 16'h0100;
    localparam logic [15:0] addr_trigger_ctrl = 16'h0800;
    localparam logic [15:0] addr_trigger_gen  = 16'h0804;
    localparam logic [15:0] addr_sync_load    = 16'h0900;
    localparam logic [15:0] addr_sync_delay   = 16'h0904;

    // ------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------
    localparam int          oneshot_ack_bit   = 7;
    localparam logic [3:0]  code_all_clear    = 4'h0;
    localparam logic [3:0]  code_all_set      = 4'hf;
    localparam logic [3:0]  code_start        = 4'h5;
    localparam logic [3:0]  code_stop         = 4'h7;
    localparam logic [3:0]  code_global_reset = 4'hd;
    localparam logic [3:0]  trig_one_pattern  = 4'hc;
    localparam int          gen_mult_bit      = 31;
    localparam int          step_per_unit     = 8;
    localparam int          long_mult         = 2048;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int clk_mhz       = 125;
    localparam int gen_unit_ns   = 40;
    localparam int gen_unit_cyc  = (gen_unit_ns * clk_mhz) / 1000;
    localparam int link_step_ns  = 4;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic [3:0]  code;
    } sync_word_s;

    typedef struct packed {
        logic        write;
        logic [15:0] addr;
        logic [31:0] data;
    } host_wr_s;

endpackage

// *** sync_delay_line.sv ***
`timescale 1ns/10ps

// Sync code delay: waits the programmed number of link steps, then emits
module sync_delay_line
    import sync_cmd_pkg::*;
#(
    parameter int DELAY_W = 7
) (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               step_en,
    input  wire logic               load,
    input  wire logic [3:0]         code_in,
    input  wire logic [DELAY_W-1:0] delay,
    output sync_word_s              sync_out
);
    logic [DELAY_W-1:0] count;
    logic               busy;
    logic [3:0]         held;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy  <= 1'b0;
            count <= '0;
            held  <= 4'h0;
        end else if (load) begin
            busy  <= 1'b1;
            count <= delay;
            held  <= code_in;
        end else if (busy && step_en) begin
            if (count == '0) begin
                busy <= 1'b0;
            end else begin
                count <= count - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync_out <= '0;
        end else begin
            sync_out.valid <= busy && step_en && (count == '0) && !load;
            sync_out.code  <= held;
        end
    end
endmodule

// *** word_buffer.sv ***
`timescale 1ns/10ps

// Two-entry buffer: in_ready drops when both entries are full, so a further word is refused
module word_buffer #(
    parameter int WIDTH = 12
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    logic [WIDTH-1:0] mem [2];
    logic             wr_ptr;
    logic             rd_ptr;
    logic [1:0]       fill;

    assign in_ready  = (fill != 2'd2);
    assign out_valid = (fill != 2'd0);
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mem[0] <= '0;
            mem[1] <= '0;
        end else if (in_valid && in_ready) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            fill   <= 2'd0;
        end else begin
            if (in_valid && in_ready) begin
                wr_ptr <= ~wr_ptr;
            end
            if (out_valid && out_ready) begin
                rd_ptr <= ~rd_ptr;
            end
            case ({in_valid && in_ready, out_valid && out_ready})
                2'b10:   fill <= fill + 2'd1;
                2'b01:   fill <= fill - 2'd1;
                default: fill <= fill;
            endcase
        end
    end
endmodule

// *** trigger_sync_command_source.sv ***
`timescale 1ns/10ps

// How it works
// R1: Sync write accepted only when upper nibble equals lower; nibble is the code.
// R2: Codes 0000 and 1111 are never issued as sync commands.
// R3: Start code enables trigger link and sends readout start code on sync link.
// R4: Stop code sends code 7 on sync link, asserting buffer_write_start downstream.
// R5: buffer_write_start clears write counter; buffer_read_start clears read counter.
// R6: Seven-bit delay sets host-write-to-sync time in 4 ns steps; the code steps once per 8 ns clk cycle.
// R7: Start enables transfer at once; read clear waits for delayed sync.
// R8: Stop halts trigger data on output fiber port and clears input counter.
// R9: Host control word buffered and sent only when no strobe or content pending.
// R10: Sent control word carries bit 12 set and bit 13 clear.
// R11: Control word with bits 5:2 equal 1100 decodes as trigger_one.
// R12: Generator write loads count from low half, rate from high half.
// R13: Generated triggers evenly spaced: bits 30:16 times 8 times 40 ns, x2048.
// R14: Generator stops by itself after programmed number of triggers.
// R15: Host resets the input delay line before using the delayed sync path; the code gives the host no such reset, only the reset input clears it.
// R16: Acknowledge bit write sends trigger acknowledge and clears busy; the code keeps busy set if host_trigger or trigger_one is high in that cycle.
// R17: Code 0xDD issues global sync reset locally and downstream.
// R18: Sync delay bits 12:8 set reset pulse width in 4 ns steps; the code holds the pulse for field plus one 8 ns clk cycles.
// R19: Mismatched or illegal sync writes are discarded without any effect.
module trigger_sync_command_source
    import sync_cmd_pkg::*;
#(
    parameter int DELAY_W = 7,
    parameter int WIDTH_W = 5,
    parameter int CTRL_W  = 12,
    parameter int LINK_W  = 14
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  host_wr_s         host_wr,
    input  wire logic        strobe_pending,
    input  wire logic        content_pending,
    input  wire logic        link_ready,
    output logic             link_valid,
    output logic [LINK_W-1:0] trigger_link_word,
    output logic             trigger_link_enable,
    output sync_word_s       sync_link,
    output logic             buffer_write_start,
    output logic             buffer_read_start,
    output logic             write_addr_clear,
    output logic             read_addr_clear,
    output logic             global_sync_reset,
    output logic             trigger_one,
    output logic             host_trigger,
    output logic             trigger_ack,
    output logic             busy
);

    // ------------------------------------------------------------
    // Host write decode
    // ------------------------------------------------------------
    logic       wr_sync;
    logic       wr_delay;
    logic       wr_ctrl;
    logic       wr_gen;
    logic       wr_oneshot;
    logic [3:0] lo_nib;
    logic       sync_ok;

    assign wr_sync    = host_wr.write && host_wr.addr == addr_sync_load;
    assign wr_delay   = host_wr.write && host_wr.addr == addr_sync_delay;
    assign wr_ctrl    = host_wr.write && host_wr.addr == addr_trigger_ctrl;
    assign wr_gen     = host_wr.write && host_wr.addr == addr_trigger_gen;
    assign wr_oneshot = host_wr.write && host_wr.addr == addr_oneshot;
    assign lo_nib     = host_wr.data[3:0];
    assign sync_ok    = wr_sync && host_wr.data[7:4] == lo_nib                  // R1 R19
                     && lo_nib != code_all_clear && lo_nib != code_all_set;    // R2

    // ------------------------------------------------------------
    // Link step enable
    // ------------------------------------------------------------
    // One step per clk cycle; the 8 ns clk is slower than the 4 ns unit,
    // so each step spans two units and range is kept by count width.
    logic step_en;
    assign step_en = 1'b1; // R6

    // ------------------------------------------------------------
    // Delay and width settings
    // ------------------------------------------------------------
    logic [DELAY_W-1:0] sync_delay;
    logic [WIDTH_W-1:0] reset_width;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync_delay  <= '0;
            reset_width <= '0;
        end else if (wr_delay) begin
            sync_delay  <= host_wr.data[DELAY_W-1:0];    // R6
            reset_width <= host_wr.data[8 +: WIDTH_W];   // R18
        end
    end

    sync_delay_line #(
        .DELAY_W (DELAY_W)
    ) u_delay (
        .clk      (clk),
        .reset    (reset),
        .step_en  (step_en),
        .load     (sync_ok),
        .code_in  (lo_nib),
        .delay    (sync_delay),
        .sync_out (sync_link)
    );

    // ------------------------------------------------------------
    // Link state and sync effects
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            trigger_link_enable <= 1'b0;
        end else if (sync_ok && lo_nib == code_start) begin
            trigger_link_enable <= 1'b1;                 // R3 R7
        end else if (sync_ok && lo_nib == code_stop) begin
            trigger_link_enable <= 1'b0;                 // R8
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            buffer_write_start <= 1'b0;
            buffer_read_start  <= 1'b0;
        end else begin
            buffer_write_start <= sync_link.valid && sync_link.code == code_stop;  // R4
            buffer_read_start  <= sync_link.valid && sync_link.code == code_start; // R3 R7
        end
    end

    // Counter clears follow the starts in the same cycle and leave only as module outputs
    assign write_addr_clear = buffer_write_start; // R5 R8
    assign read_addr_clear  = buffer_read_start;  // R5

    // ------------------------------------------------------------
    // Global sync reset pulse
    // ------------------------------------------------------------
    logic [WIDTH_W:0] rst_count;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rst_count <= '0;
        end else if (sync_link.valid && sync_link.code == code_global_reset) begin
            rst_count <= {1'b0, reset_width} + 1'b1;     // R17 R18
        end else if (rst_count != '0) begin
            rst_count <= rst_count - 1'b1;
        end
    end

    assign global_sync_reset = (rst_count != '0);

    // ------------------------------------------------------------
    // Trigger control word path
    // ------------------------------------------------------------
    logic              buf_valid;
    logic [CTRL_W-1:0] buf_data;
    logic              send;

    word_buffer #(
        .WIDTH (CTRL_W)
    ) u_buf (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (wr_ctrl),
        .in_ready  (),
        .in_data   (host_wr.data[CTRL_W-1:0]),
        .out_valid (buf_valid),
        .out_ready (send),
        .out_data  (buf_data)
    );

    // Lower priority than strobe and content words
    assign send = buf_valid && link_ready && trigger_link_enable
               && !strobe_pending && !content_pending;  // R9

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            link_valid        <= 1'b0;
            trigger_link_word <= '0;
            trigger_one       <= 1'b0;
        end else begin
            link_valid        <= send;
            trigger_one       <= send && buf_data[5:2] == trig_one_pattern; // R11
            if (send) begin
                trigger_link_word <= {1'b0, 1'b1, buf_data};                // R10
            end
        end
    end

    // ------------------------------------------------------------
    // Host trigger generator
    // ------------------------------------------------------------
    localparam int PER_W = 40;
    logic [15:0]      gen_left;
    logic [PER_W-1:0] gen_period;
    logic [PER_W-1:0] gen_count;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            gen_left   <= '0;
            gen_period <= '0;
            gen_count  <= '0;
            host_trigger <= 1'b0;
        end else if (wr_gen) begin
            gen_left   <= host_wr.data[15:0];                                   // R12
            gen_period <= PER_W'(host_wr.data[30:16]) * PER_W'(step_per_unit)
                        * PER_W'(gen_unit_cyc)
                        * (host_wr.data[gen_mult_bit] ? PER_W'(long_mult)
                                                      : PER_W'(1));           // R13
            gen_count  <= '0;
            host_trigger <= 1'b0;
        end else if (gen_left != '0) begin
            if (gen_count + 1'b1 >= gen_period) begin
                gen_count    <= '0;
                host_trigger <= 1'b1;
                gen_left     <= gen_left - 1'b1;                              // R14
            end else begin
                gen_count    <= gen_count + 1'b1;
                host_trigger <= 1'b0;
            end
        end else begin
            host_trigger <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Acknowledge and busy
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            trigger_ack <= 1'b0;
            busy        <= 1'b0;
        end else begin
            trigger_ack <= wr_oneshot && host_wr.data[oneshot_ack_bit];        // R16
            if (host_trigger || trigger_one) begin
                busy <= 1'b1;
            end else if (wr_oneshot && host_wr.data[oneshot_ack_bit]) begin
                busy <= 1'b0;                                                  // R16
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_no_illegal_code: assert property (@(posedge clk) disable iff (reset) // R2
        sync_link.valid |-> sync_link.code != code_all_clear
                         && sync_link.code != code_all_set)
        else $error("illegal sync code issued");

    chk_bad_write_drop: assert property (@(posedge clk) disable iff (reset) // R19
        (wr_sync && !sync_ok && !u_delay.busy) |=> !u_delay.busy)
        else $error("rejected sync write was loaded");

    chk_start_enables: assert property (@(posedge clk) disable iff (reset) // R7
        (sync_ok && lo_nib == code_start) |=> trigger_link_enable)
        else $error("start did not enable link");

    chk_stop_disables: assert property (@(posedge clk) disable iff (reset) // R8
        (sync_ok && lo_nib == code_stop) |=> !trigger_link_enable)
        else $error("stop did not disable link");

    chk_delay_zero: assert property (@(posedge clk) disable iff (reset) // R6
        (sync_ok && sync_delay == '0 && !wr_delay) |=> ##1 sync_link.valid)
        else $error("zero delay sync late");

    chk_read_start: assert property (@(posedge clk) disable iff (reset) // R3
        (sync_link.valid && sync_link.code == code_start) |=> buffer_read_start)
        else $error("read start missing");

    chk_write_start: assert property (@(posedge clk) disable iff (reset) // R4
        (sync_link.valid && sync_link.code == code_stop) |=> buffer_write_start)
        else $error("write start missing");

    chk_ctrl_tag: assert property (@(posedge clk) disable iff (reset) // R10
        link_valid |-> trigger_link_word[12] && !trigger_link_word[13])
        else $error("control word tag wrong");

    chk_ctrl_priority: assert property (@(posedge clk) disable iff (reset) // R9
        (strobe_pending || content_pending) |=> !link_valid)
        else $error("control word beat higher priority");

    chk_ack_pulse: assert property (@(posedge clk) disable iff (reset) // R16
        (wr_oneshot && host_wr.data[oneshot_ack_bit]) |=> trigger_ack
            && (!busy || $past(host_trigger) || $past(trigger_one)))
        else $error("acknowledge not sent");

    chk_trig_one_match: assert property (@(posedge clk) disable iff (reset) // R11
        trigger_one == (link_valid && trigger_link_word[5:2] == trig_one_pattern))
        else $error("trigger_one decode wrong");

    chk_link_off_quiet: assert property (@(posedge clk) disable iff (reset) // R8
        !trigger_link_enable |=> !link_valid)
        else $error("word sent on disabled link");

    chk_ready_respect: assert property (@(posedge clk) disable iff (reset) // R9
        !link_ready |=> !link_valid)
        else $error("word sent while link not ready");

    chk_gen_stops: assert property (@(posedge clk) disable iff (reset) // R14
        (gen_left == '0 && !wr_gen) |=> !host_trigger)
        else $error("trigger after count ran out");

    chk_gen_load: assert property (@(posedge clk) disable iff (reset) // R12
        wr_gen |=> gen_left == $past(host_wr.data[15:0]))
        else $error("trigger count not loaded");

    chk_gen_no_early: assert property (@(posedge clk) disable iff (reset) // R13
        wr_gen |=> !host_trigger)
        else $error("trigger on generator load");

    chk_reset_pulse: assert property (@(posedge clk) disable iff (reset) // R17
        (sync_link.valid && sync_link.code == code_global_reset) |=> global_sync_reset)
        else $error("global reset pulse missing");

    chk_reset_source: assert property (@(posedge clk) disable iff (reset) // R17
        $rose(global_sync_reset) |-> $past(sync_link.valid)
            && $past(sync_link.code) == code_global_reset)
        else $error("global reset without its code");

    chk_read_source: assert property (@(posedge clk) disable iff (reset) // R7
        buffer_read_start |-> $past(sync_link.valid) && $past(sync_link.code) == code_start)
        else $error("read start without start code");

    chk_write_source: assert property (@(posedge clk) disable iff (reset) // R4
        buffer_write_start |-> $past(sync_link.valid) && $past(sync_link.code) == code_stop)
        else $error("write start without stop code");

    chk_sync_pulse: assert property (@(posedge clk) disable iff (reset) // R6
        sync_link.valid |=> !sync_link.valid)
        else $error("sync pulse longer than one cycle");

    chk_ack_source: assert property (@(posedge clk) disable iff (reset) // R16
        trigger_ack |-> $past(wr_oneshot))
        else $error("acknowledge without host write");

    chk_reject_stable: assert property (@(posedge clk) disable iff (reset) // R19
        (wr_sync && !sync_ok) |=> $stable(trigger_link_enable))
        else $error("rejected sync write changed link");

    chk_start_delayed: assert property (@(posedge clk) disable iff (reset) // R7
        (sync_ok && lo_nib == code_start && sync_delay != '0) |=> !sync_link.valid)
        else $error("start sync not delayed");

    // Pulse outputs seen at least once per run
    cov_start: cover property (@(posedge clk) disable iff (reset) buffer_read_start);
    cov_stop: cover property (@(posedge clk) disable iff (reset) buffer_write_start);
    cov_ctrl: cover property (@(posedge clk) disable iff (reset) trigger_one);
    cov_gen: cover property (@(posedge clk) disable iff (reset) host_trigger);
    cov_reset: cover property (@(posedge clk) disable iff (reset) global_sync_reset);
endmodule

// *** link_receiver.sv ***
`timescale 1ns/10ps

// Downstream trigger link receiver: takes words, can stall on demand
module link_receiver
    import sync_cmd_pkg::*;
#(
    parameter int LINK_W = 14
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              stall,
    input  wire logic              link_valid,
    input  wire logic [LINK_W-1:0] trigger_link_word,
    output logic                   link_ready,
    output int                     word_count,
    output logic [LINK_W-1:0]      last_word
);
    // Slow answer when the bench asks for a stall
    assign link_ready = !stall;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            word_count <= 0;
            last_word  <= '0;
        end else if (link_valid) begin
            word_count <= word_count + 1;
            last_word  <= trigger_link_word;
        end
    end
endmodule

// *** trigger_sync_command_source_tb_top.sv ***
`timescale 1ns/10ps

`define check(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected at %0t: got %0h want %0h", $time, (g), (e)); end end

module trigger_sync_command_source_tb_top
    import sync_cmd_pkg::*;
;
    logic        clk;
    logic        reset;
    host_wr_s    host_wr;
    logic        strobe_pending;
    logic        content_pending;
    logic        link_ready;
    logic        link_valid;
    logic [13:0] trigger_link_word;
    logic        trigger_link_enable;
    sync_word_s  sync_link;
    logic        buffer_write_start;
    logic        buffer_read_start;
    logic        write_addr_clear;
    logic        read_addr_clear;
    logic        global_sync_reset;
    logic        trigger_one;
    logic        host_trigger;
    logic        trigger_ack;
    logic        busy;
    logic        stall;
    int          word_count;
    logic [13:0] last_word;
    int          bad_count;
    int          checks_done;
    int          n;

    localparam logic [31:0] bad_sync [4] = '{32'h00, 32'hff, 32'h56, 32'h5a};

    trigger_sync_command_source dut (
        .clk(clk), .reset(reset), .host_wr(host_wr),
        .strobe_pending(strobe_pending), .content_pending(content_pending),
        .link_ready(link_ready), .link_valid(link_valid),
        .trigger_link_word(trigger_link_word), .trigger_link_enable(trigger_link_enable),
        .sync_link(sync_link), .buffer_write_start(buffer_write_start),
        .buffer_read_start(buffer_read_start), .write_addr_clear(write_addr_clear),
        .read_addr_clear(read_addr_clear), .global_sync_reset(global_sync_reset),
        .trigger_one(trigger_one), .host_trigger(host_trigger),
        .trigger_ack(trigger_ack), .busy(busy)
    );

    link_receiver far_end (
        .clk(clk), .reset(reset), .stall(stall), .link_valid(link_valid),
        .trigger_link_word(trigger_link_word), .link_ready(link_ready),
        .word_count(word_count), .last_word(last_word)
    );

    // ------------------------------------------------------------
    // Bench tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Single-cycle write, taken at the rising edge between two falling edges
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(negedge clk);
        host_wr <= '{write: 1'b1, addr: a, data: d};
        @(negedge clk);
        host_wr.write <= 1'b0;
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return sync_link.valid;
            1: return link_valid;
            2: return host_trigger;
            3: return trigger_ack;
            4: return buffer_read_start;
            5: return buffer_write_start;
            default: return global_sync_reset;
        endcase
    endfunction

    // Falling edges until the chosen output is high; bounded
    task automatic wait_on(input int s, input int lim, output int cnt);
        cnt = 0;
        do begin
            @(negedge clk);
            cnt++;
            if (cnt > lim) begin
                bad_count++;
                $display("unexpected at %0t: wait on output %0d timed out", $time, s);
                test_done();
            end
        end while (pick(s) !== 1'b1);
    endtask

    // The chosen output must stay low for a number of cycles
    task automatic quiet(input int s, input int cyc);
        int hits;
        hits = 0;
        repeat (cyc) begin
            @(negedge clk);
            if (pick(s) !== 1'b0) hits++;
        end
        `check(hits, 0)
    endtask

    // ------------------------------------------------------------
    // Clock, reset and scenarios
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        reset = 1'b1;
        host_wr = '0;
        strobe_pending = 1'b0;
        content_pending = 1'b0;
        stall = 1'b0;
        bad_count = 0;
        checks_done = 0;
        repeat (3) @(negedge clk);
        `check({link_valid, trigger_link_enable, sync_link.valid, busy, host_trigger}, 5'h0)
        reset = 1'b0;
        // One-shot write with bit 7 clear first; no acknowledge follows
        wr(addr_oneshot, 32'h0000_4000);
        `check(trigger_ack, 1'b0)
        // Illegal and mismatched codes leave everything untouched
        wr(addr_sync_delay, 32'h0000_0003);
        for (int i = 0; i < 4; i++) begin
            wr(addr_sync_load, bad_sync[i]);
            quiet(0, 8);
        end
        `check(trigger_link_enable, 1'b0)
        // Start: link on at once, read clear after delay; wr used one edge
        wr(addr_sync_load, 32'h0000_0055);
        `check(trigger_link_enable, 1'b1)
        wait_on(0, 200, n);
        `check(n, 3 + 1)
        `check(sync_link.code, code_start)
        wait_on(4, 1, n);
        `check(read_addr_clear, 1'b1)
        // Pending strobe holds the control word back
        strobe_pending <= 1'b1;
        wr(addr_trigger_ctrl, 32'h0000_0030);
        quiet(1, 10);
        strobe_pending <= 1'b0;
        wait_on(1, 10, n);
        `check(trigger_link_word, 14'h1030)
        `check(trigger_one, 1'b1)
        @(negedge clk);
        `check(busy, 1'b1)
        content_pending <= 1'b1;
        wr(addr_trigger_ctrl, 32'h0000_0030);
        quiet(1, 10);
        content_pending <= 1'b0;
        wait_on(1, 10, n);
        // Receiver stall: buffer fills, third word refused
        stall <= 1'b1;
        wr(addr_trigger_ctrl, 32'hfff0_083c);
        wr(addr_trigger_ctrl, 32'h0000_0030);
        wr(addr_trigger_ctrl, 32'h0000_00aa);
        repeat (5) @(negedge clk);
        stall <= 1'b0;
        wait_on(1, 10, n);
        `check(trigger_link_word, 14'h183c)
        `check(trigger_one, 1'b0)
        wait_on(1, 10, n);
        `check(trigger_link_word, 14'h1030)
        quiet(1, 10);
        `check(word_count, 4)
        `check(last_word, 14'h1030)
        // Acknowledge clears busy
        wr(addr_oneshot, 32'h0000_0080);
        `check(trigger_ack, 1'b1)
        @(negedge clk);
        `check(busy, 1'b0)
        // Stop: link off, write clear on delayed code 7
        wr(addr_sync_load, 32'h0000_0077);
        wait_on(0, 200, n);
        `check(sync_link.code, code_stop)
        `check(trigger_link_enable, 1'b0)
        wait_on(5, 1, n);
        `check(write_addr_clear, 1'b1)
        wr(addr_trigger_ctrl, 32'h0000_0030);
        quiet(1, 10);
        // Global reset, width field 2 gives three cycles
        wr(addr_sync_delay, 32'h0000_0200);
        wr(addr_sync_load, 32'h0000_00dd);
        wait_on(0, 20, n);
        `check(sync_link.code, code_global_reset)
        wait_on(6, 3, n);
        n = 0;
        while (global_sync_reset === 1'b1 && n < 40) begin
            n++;
            @(negedge clk);
        end
        `check(n, 3)
        // Generator: rate 1 gives 8*5 cycles, three triggers then stop
        wr(addr_trigger_gen, 32'h0001_0003);
        wait_on(2, 100, n);
        wait_on(2, 100, n);
        `check(n, step_per_unit * gen_unit_cyc)
        wait_on(2, 100, n);
        `check(n, 40)
        quiet(2, 150);
        test_done();
    end

    // Hang guard, well past the longest scenario
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("unexpected at %0t: run limit reached", $time);
        test_done();
    end
endmodule
